// >>> common/dig_pkg.sv
package dig_pkg;

  // apb register map (byte addresses)
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] MSG_OFS      = 8'h08;
  localparam logic [7:0] FEATURE_OFS  = 8'h0c;
  localparam logic [7:0] PTR_OFS      = 8'h10;
  localparam logic [7:0] IN_TYPE_OFS  = 8'h14;

  // control register fields
  localparam int CTRL_MODE_BIT     = 0;
  localparam int CTRL_ADAPT_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // status register fields
  localparam int STAT_CODE_LSB   = 0;
  localparam int STAT_VALID_BIT  = 8;
  localparam int STAT_HALT_BIT   = 9;
  localparam int STAT_BLOCK_BIT  = 10;
  localparam int STAT_STRAP_BIT  = 11;

  // message register fields (write-one pulses)
  localparam int MSG_STARTUP_BIT  = 0;
  localparam int MSG_INIT_AP_BIT  = 1;
  localparam int MSG_INIT_BSP_BIT = 2;

  // feature byte 1 position inside the feature word
  localparam int FEAT_BYTE1_LSB = 8;

  // input 0 delivery type, reset value and the external-vector code
  localparam logic [1:0] IN_TYPE_RESET  = 2'h0;
  localparam logic [1:0] TYPE_EXT_VECTOR = 2'h3;

  // default configuration codes
  localparam logic [7:0] CODE_MIN       = 8'h01;
  localparam logic [7:0] CODE_MAX       = 8'h07;
  localparam logic [7:0] CODE_EISA_NO   = 8'h02;
  localparam logic [7:0] CODE_MCA_DISC  = 8'h04;
  localparam logic [7:0] CODE_INTEG_MIN = 8'h05;
  localparam logic [7:0] CODE_MCA_INTEG = 8'h07;

  // io controller input positions
  localparam int IN_TIMER = 2;
  localparam int IN_CHAIN = 13;

  // fixed decode bases, 4 KiB windows
  localparam logic [31:0] LOCAL_BASE = 32'hfee0_0000;
  localparam logic [31:0] IO_BASE    = 32'hfec0_0000;
  localparam int          WIN_BITS   = 12;

  // local controller identifiers
  localparam logic [3:0] BSP_ID = 4'h0;
  localparam logic [3:0] AP_ID  = 4'h1;

  // level-to-edge pulse width
  localparam int CLK_PERIOD_NS   = 40;
  localparam int EDGE_PULSE_NS   = 80;
  localparam int EDGE_PULSE_CYC_I = (EDGE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] EDGE_PULSE_CYC = 3'(EDGE_PULSE_CYC_I);

  typedef enum logic {MODE_LEGACY, MODE_BYPASS_WIRE} dig_mode_e;

  // acknowledge cycle inputs from the processor bus side
  typedef struct packed {
    logic       cycle;
    logic       external_ack_select;
    logic       processor_irq_out;
    logic [7:0] pic_vector;
    logic [7:0] ctrl_vector;
    logic       ctrl_ready;
    logic       ext_ready;
  } dig_ack_in_s;

  // acknowledge cycle outputs
  typedef struct packed {
    logic       pic_ack;
    logic [7:0] vector;
    logic       cpu_ready;
    logic       blocked;
  } dig_ack_out_s;

  // per-processor local pin bundle
  typedef struct packed {
    logic local_pin0;
    logic local_pin1;
    logic sys_mgmt_irq_n;
    logic soft_init;
  } dig_cpu_pins_s;

endpackage

// >>> hdl/dig_level_to_edge_adapter.sv
// Summary of operation
// - ack cycle vector steered by external select
// - select low with irq: ack never reaches PIC
// - ready from bus logic when select active
// - PIC level request becomes edge pulse
// - codes one to seven valid, rest reserved
// - code two drops timer and chaining inputs
// - MCA codes invert io inputs one to fifteen
// - local identifiers consecutive from zero
// - fixed decode bases for both controllers
// - power-on mode legacy or bypass wire
// - AP halts until start-up message
// - non-halting AP held off boot firmware
// - strap switches local pins, smi, soft init
// - local pins share irq and nmi pins
// - targeted init leaves shared pin alone
// - external-vector type takes PIC vector
`timescale 1ns/1ps

module dig_level_to_edge_adapter (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [7:0]            cfg_code_in,
  input  wire logic                  local_ctrl_enable_strap,
  input  wire dig_pkg::dig_ack_in_s  ack_in,
  output dig_pkg::dig_ack_out_s      ack_out,
  input  wire logic                  pic_irq_out,
  input  wire logic                  nmi_in,
  input  wire logic                  sys_mgmt_irq_n_in,
  input  wire logic                  sys_init_in,
  input  wire logic                  processor_reset_out,
  input  wire logic                  ap_halts_itself,
  input  wire logic [15:0]           irq_lines,
  output logic      [15:0]           io_ctrl_inputs,
  output logic                       local_input0,
  input  wire logic [31:0]           cpu_addr,
  output logic                       local_ctrl_sel,
  output logic                       io_ctrl_sel,
  output logic      [3:0]            boot_processor_id,
  output logic      [3:0]            application_processor_id,
  output dig_pkg::dig_cpu_pins_s     boot_processor_pins,
  output dig_pkg::dig_cpu_pins_s     application_processor_pins,
  output logic                       local_ctrl_enable,
  output logic                       hard_reset_out,
  output logic                       application_processor_run
);

  typedef enum logic {AP_HALTED, AP_RUNNING} dig_ap_e;

  logic [7:0]        code_reg;
  logic              code_valid_reg;
  logic              code_taken_reg;
  logic              strap_reg;
  logic [1:0]        ctrl_reg;
  logic [1:0]        in_type_reg;
  logic              startup_pulse;
  logic              init_ap_pulse;
  logic              init_bsp_pulse;
  dig_ap_e           ap_state_reg;
  logic              irq_d_reg;
  logic              ack_d_reg;
  logic [2:0]        edge_cnt_reg;
  logic              edge_out_reg;
  logic              adapt_en;
  logic              block_reg;
  logic [7:0]        vector_reg;
  logic              ext_sel_eff;
  logic              integrated;
  logic              mca_code;
  logic              soft_init_src;
  logic              wr_en;
  logic              rd_en;
  logic              addr_ok;
  logic [31:0]       rd_word;
  dig_pkg::dig_mode_e mode;

  function automatic logic in_window(input logic [31:0] a, input logic [31:0] base);
    in_window = (a[31:dig_pkg::WIN_BITS] == base[31:dig_pkg::WIN_BITS]);
  endfunction

  function automatic logic code_ok(input logic [7:0] c);
    code_ok = (c >= dig_pkg::CODE_MIN) && (c <= dig_pkg::CODE_MAX);
  endfunction

  // configuration code and strap, caught on the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg       <= 8'h00;
      code_valid_reg <= 1'b0;
      code_taken_reg <= 1'b0;
      strap_reg      <= 1'b0;
    end else if (!code_taken_reg) begin
      code_taken_reg <= 1'b1;
      code_reg       <= cfg_code_in;
      code_valid_reg <= code_ok(cfg_code_in);
      strap_reg      <= local_ctrl_enable_strap;
    end
  end

  assign integrated = code_valid_reg && (code_reg >= dig_pkg::CODE_INTEG_MIN);
  assign mca_code   = code_valid_reg &&
                      ((code_reg == dig_pkg::CODE_MCA_DISC) ||
                       (code_reg == dig_pkg::CODE_MCA_INTEG));
  assign mode       = dig_pkg::dig_mode_e'(ctrl_reg[dig_pkg::CTRL_MODE_BIT]);
  // adapter enable gates every cycle of the pulse, not only the first
  assign adapt_en   = ctrl_reg[dig_pkg::CTRL_ADAPT_EN_BIT];

  // apb slave, zero wait states
  assign addr_ok = (paddr == dig_pkg::CTRL_OFS)    || (paddr == dig_pkg::STATUS_OFS) ||
                   (paddr == dig_pkg::MSG_OFS)     || (paddr == dig_pkg::FEATURE_OFS) ||
                   (paddr == dig_pkg::PTR_OFS)     || (paddr == dig_pkg::IN_TYPE_OFS);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= dig_pkg::CTRL_RESET;
      in_type_reg <= dig_pkg::IN_TYPE_RESET;
    end else if (wr_en) begin
      if (paddr == dig_pkg::CTRL_OFS) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (paddr == dig_pkg::IN_TYPE_OFS) begin
        in_type_reg <= pwdata[1:0];
      end
    end
  end

  // message pulses, one cycle per accepted write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_pulse  <= 1'b0;
      init_ap_pulse  <= 1'b0;
      init_bsp_pulse <= 1'b0;
    end else begin
      startup_pulse  <= wr_en && (paddr == dig_pkg::MSG_OFS) &&
                        pwdata[dig_pkg::MSG_STARTUP_BIT];
      init_ap_pulse  <= wr_en && (paddr == dig_pkg::MSG_OFS) &&
                        pwdata[dig_pkg::MSG_INIT_AP_BIT];
      init_bsp_pulse <= wr_en && (paddr == dig_pkg::MSG_OFS) &&
                        pwdata[dig_pkg::MSG_INIT_BSP_BIT];
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      dig_pkg::CTRL_OFS: begin
        rd_word[1:0] = ctrl_reg;
      end
      dig_pkg::STATUS_OFS: begin
        rd_word[dig_pkg::STAT_CODE_LSB +: 8] = code_reg;
        rd_word[dig_pkg::STAT_VALID_BIT]     = code_valid_reg;
        rd_word[dig_pkg::STAT_HALT_BIT]      = (ap_state_reg == AP_HALTED);
        rd_word[dig_pkg::STAT_BLOCK_BIT]     = block_reg;
        rd_word[dig_pkg::STAT_STRAP_BIT]     = strap_reg;
      end
      dig_pkg::FEATURE_OFS: begin
        rd_word[dig_pkg::FEAT_BYTE1_LSB +: 8] = code_reg;
      end
      dig_pkg::PTR_OFS: begin
        rd_word = 32'h0000_0000;
      end
      dig_pkg::IN_TYPE_OFS: begin
        rd_word[1:0] = in_type_reg;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end else if (rd_en) begin
      prdata <= prdata;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // acknowledge trap
  assign ext_sel_eff = ack_in.external_ack_select ||
                       (in_type_reg == dig_pkg::TYPE_EXT_VECTOR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_reg <= 1'b0;
    end else if (ack_in.processor_irq_out && !ext_sel_eff) begin
      block_reg <= 1'b1;
    end else if (ext_sel_eff) begin
      // sticky until ext_sel_eff goes high, which clears it with or without an ack cycle
      block_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_reg <= 8'h00;
    end else if (ack_in.cycle) begin
      vector_reg <= ext_sel_eff ? ack_in.pic_vector : ack_in.ctrl_vector;
    end
  end

  always_comb begin
    ack_out.pic_ack   = ack_in.cycle && ext_sel_eff && !block_reg;
    ack_out.vector    = vector_reg;
    ack_out.blocked   = block_reg;
    ack_out.cpu_ready = ack_in.ctrl_ready;
    if (ack_in.cycle && ext_sel_eff) begin
      ack_out.cpu_ready = ack_in.ext_ready;
    end
  end

  // level-to-edge adapter: pulse on rise, re-pulse after ack if still high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_d_reg    <= 1'b0;
      ack_d_reg    <= 1'b0;
      edge_cnt_reg <= 3'h0;
      edge_out_reg <= 1'b0;
    end else begin
      irq_d_reg <= pic_irq_out;
      ack_d_reg <= ack_out.pic_ack;
      if ((pic_irq_out && !irq_d_reg) ||
          (ack_d_reg && !ack_out.pic_ack && pic_irq_out)) begin
        edge_cnt_reg <= dig_pkg::EDGE_PULSE_CYC;
        edge_out_reg <= adapt_en;
      end else if (edge_cnt_reg != 3'h0) begin
        edge_cnt_reg <= edge_cnt_reg - 3'h1;
        edge_out_reg <= adapt_en && (edge_cnt_reg != 3'h1);
      end else begin
        edge_out_reg <= 1'b0;
      end
    end
  end

  assign local_input0 = edge_out_reg;

  // io controller input wiring by configuration code
  always_comb begin
    io_ctrl_inputs    = irq_lines;
    io_ctrl_inputs[0] = edge_out_reg;
    if (mca_code) begin
      io_ctrl_inputs[15:1] = ~irq_lines[15:1];
    end
    if (code_valid_reg && (code_reg == dig_pkg::CODE_EISA_NO)) begin
      io_ctrl_inputs[dig_pkg::IN_TIMER] = 1'b0;
      io_ctrl_inputs[dig_pkg::IN_CHAIN] = 1'b0;
    end
    // input 0 left unconnected on the mca integrated variant
    if (code_reg == dig_pkg::CODE_MCA_INTEG) begin
      io_ctrl_inputs[0] = 1'b0;
    end
    if (!code_valid_reg) begin
      io_ctrl_inputs = 16'h0000;
    end
  end

  // fixed decode and identifiers
  assign local_ctrl_sel           = in_window(cpu_addr, dig_pkg::LOCAL_BASE);
  assign io_ctrl_sel              = in_window(cpu_addr, dig_pkg::IO_BASE);
  assign boot_processor_id        = dig_pkg::BSP_ID;
  assign application_processor_id = dig_pkg::AP_ID;

  // reset-out steering
  assign soft_init_src  = sys_init_in || (integrated && processor_reset_out);
  assign hard_reset_out = !integrated && processor_reset_out;

  // application processor halt control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ap_state_reg <= AP_HALTED;
    end else begin
      case (ap_state_reg)
        AP_HALTED: begin
          if (startup_pulse && !soft_init_src && !init_ap_pulse) begin
            ap_state_reg <= AP_RUNNING;
          end
        end
        AP_RUNNING: begin
          if (soft_init_src || init_ap_pulse || hard_reset_out) begin
            ap_state_reg <= AP_HALTED;
          end
        end
        default: begin
          ap_state_reg <= AP_HALTED;
        end
      endcase
    end
  end

  // self-halting parts run freely; others are held off until started
  assign application_processor_run = ap_halts_itself ||
                                     (ap_state_reg == AP_RUNNING);

  // local pins, cross-connected to both processors only with the strap set in bypass wire mode
  assign local_ctrl_enable = strap_reg;

  always_comb begin
    boot_processor_pins.local_pin0     = pic_irq_out;
    boot_processor_pins.local_pin1     = nmi_in;
    boot_processor_pins.sys_mgmt_irq_n = sys_mgmt_irq_n_in;
    boot_processor_pins.soft_init      = soft_init_src;
    application_processor_pins         = boot_processor_pins;
    if (strap_reg) begin
      // legacy mode keeps pic irq and nmi off the ap
      if (mode == dig_pkg::MODE_LEGACY) begin
        application_processor_pins.local_pin0 = 1'b0;
        application_processor_pins.local_pin1 = 1'b0;
      end else begin
        boot_processor_pins.local_pin0        = edge_out_reg;
        application_processor_pins.local_pin0 = edge_out_reg;
      end
    end else begin
      application_processor_pins.sys_mgmt_irq_n = 1'b1;
      application_processor_pins.soft_init      = 1'b0;
      application_processor_pins.local_pin0     = 1'b0;
      application_processor_pins.local_pin1     = 1'b0;
    end
  end

  // targeted init: internal halt only for AP, bsp request is left unused
  logic unused_bsp_init;
  assign unused_bsp_init = init_bsp_pulse;

endmodule // dig_level_to_edge_adapter

// >>> bench/dig_level_to_edge_adapter_properties.sv
`timescale 1ns/1ps
module dig_level_to_edge_adapter_properties (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire dig_pkg::dig_ack_in_s  ack_in,
  input wire dig_pkg::dig_ack_out_s ack_out,
  input wire logic                  pic_irq_out,
  input wire logic                  local_input0,
  input wire logic [31:0]           cpu_addr,
  input wire logic                  local_ctrl_sel,
  input wire logic                  io_ctrl_sel,
  input wire logic                  application_processor_run,
  input wire logic                  ap_halts_itself
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire start_wr = psel && penable && pwrite && paddr == dig_pkg::MSG_OFS && pwdata[0];
  wire ctrl_src = ack_in.cycle && !ack_out.pic_ack && !ack_out.blocked;
  // mirror of the adapter enable bit, taken from accepted apb writes
  logic adapt_en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) adapt_en <= dig_pkg::CTRL_RESET[dig_pkg::CTRL_ADAPT_EN_BIT];
    else if (psel && penable && pwrite && paddr == dig_pkg::CTRL_OFS)
      adapt_en <= pwdata[dig_pkg::CTRL_ADAPT_EN_BIT];
  end
  chk_vec_pic: assert property (
    ack_in.cycle && ack_in.external_ack_select |=> ack_out.vector == $past(ack_in.pic_vector))
    else $error("ack vector not from pic");
  chk_vec_ctrl: assert property (
    ctrl_src && !ack_in.external_ack_select |=> ack_out.vector == $past(ack_in.ctrl_vector))
    else $error("ack vector not from controller");
  chk_block_sets: assert property (
    ctrl_src && ack_in.processor_irq_out && !ack_in.external_ack_select |=> ack_out.blocked)
    else $error("blocked flag not set");
  chk_block_no_ack: assert property (ack_out.blocked |-> !ack_out.pic_ack)
    else $error("blocked cycle reached pic");
  chk_ready_ext: assert property (
    ack_in.cycle && ack_in.external_ack_select |-> ack_out.cpu_ready == ack_in.ext_ready)
    else $error("ready not from bus logic");
  chk_edge_pulse: assert property (
    $rose(pic_irq_out) && !local_input0 && adapt_en |=> local_input0 [*2] ##1 !local_input0)
    else $error("edge pulse width wrong");
  chk_adapt_off: assert property (!$past(adapt_en) |-> !local_input0)
    else $error("edge pulse while adapter off");
  chk_base_decode: assert property (
    local_ctrl_sel == (cpu_addr[31:12] == 20'hfee00) && io_ctrl_sel == (cpu_addr[31:12] == 20'hfec00))
    else $error("controller decode wrong");
  chk_ap_start: assert property (
    $rose(application_processor_run) && !ap_halts_itself |-> $past(start_wr, 2))
    else $error("ap ran without start-up message");
endmodule // dig_level_to_edge_adapter_properties

bind dig_level_to_edge_adapter dig_level_to_edge_adapter_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .ack_in, .ack_out, .pic_irq_out, .local_input0, .cpu_addr, .local_ctrl_sel,
  .io_ctrl_sel, .application_processor_run, .ap_halts_itself);

// >>> bench/dig_cpu_bus_model.sv
`timescale 1ns/1ps
module dig_cpu_bus_model (
  input  wire logic                  pclk,
  input  wire dig_pkg::dig_ack_out_s ack_out,
  output dig_pkg::dig_ack_in_s       ack_in
);
  logic saw_ack = 1'b0;
  initial ack_in = '0;
  always @(posedge pclk) if (!ack_in.cycle) saw_ack <= 1'b0;
    else if (ack_out.pic_ack === 1'b1) saw_ack <= 1'b1;
  task automatic do_ack(input logic sel, irq, ext, input int nw, input logic [7:0] pv, cv,
                        output logic [7:0] vec, output logic saw, output logic ok);
    int n;
    n = 0;
    @(posedge pclk);
    ack_in.cycle <= 1'b1;
    ack_in.external_ack_select <= sel;
    ack_in.processor_irq_out <= irq;
    ack_in.pic_vector <= pv;
    ack_in.ctrl_vector <= cv;
    repeat (nw) @(posedge pclk);
    // controller stays silent on external-vector acks
    if (ext) ack_in.ext_ready <= 1'b1;
    else ack_in.ctrl_ready <= 1'b1;
    do begin @(posedge pclk); n++; end while (ack_out.cpu_ready !== 1'b1 && n < 20);
    ok = (ack_out.cpu_ready === 1'b1);
    vec = ack_out.vector;
    saw = saw_ack;
    ack_in.cycle <= 1'b0;
    ack_in.ext_ready <= 1'b0;
    ack_in.ctrl_ready <= 1'b0;
    ack_in.external_ack_select <= 1'b0;
    ack_in.processor_irq_out <= 1'b0;
    // released vector lines drift off their last value
    ack_in.pic_vector <= ~pv;
    ack_in.ctrl_vector <= ~cv;
  endtask
endmodule // dig_cpu_bus_model

// >>> bench/tb_dig_level_to_edge_adapter.sv
`timescale 1ns/1ps
module tb_dig_level_to_edge_adapter;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, cfg_code_in = 8'h03, vec;
  logic [31:0] pwdata = 32'h0, cpu_addr = 32'h0, prdata, rd;
  logic pready, pslverr, local_input0, local_ctrl_sel, io_ctrl_sel, local_ctrl_enable;
  logic hard_reset_out, application_processor_run, err, saw, ok;
  logic local_ctrl_enable_strap = 1'b1, pic_irq_out = 1'b0, nmi_in = 1'b0;
  logic sys_mgmt_irq_n_in = 1'b1, sys_init_in = 1'b0, processor_reset_out = 1'b0;
  logic ap_halts_itself = 1'b0;
  logic [15:0] irq_lines = 16'ha5a4, io_ctrl_inputs;
  logic [3:0] boot_processor_id, application_processor_id;
  logic [31:0] addrs [6] = '{32'hfee0_0000, 32'hfee0_0ffc, 32'hfee0_1000, 32'hfec0_0000,
                            32'hfec0_0ff0, 32'h0000_0000};
  dig_pkg::dig_ack_in_s ack_in;
  dig_pkg::dig_ack_out_s ack_out;
  dig_pkg::dig_cpu_pins_s boot_processor_pins, application_processor_pins;
  int bad_count = 0, num_checks = 0;

  always #20 pclk = ~pclk;
  dig_level_to_edge_adapter i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cfg_code_in, .local_ctrl_enable_strap, .ack_in, .ack_out, .pic_irq_out, .nmi_in,
    .sys_mgmt_irq_n_in, .sys_init_in, .processor_reset_out, .ap_halts_itself, .irq_lines,
    .io_ctrl_inputs, .local_input0, .cpu_addr, .local_ctrl_sel, .io_ctrl_sel,
    .boot_processor_id, .application_processor_id, .boot_processor_pins,
    .application_processor_pins, .local_ctrl_enable, .hard_reset_out,
    .application_processor_run);
  dig_cpu_bus_model i_cpu (.pclk, .ack_out, .ack_in);

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      $display("Error apb wait expected 1 seen %b", pready);
      bad_count++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rst(input logic [7:0] c);
    @(posedge pclk);
    presetn <= 1'b0; cfg_code_in <= c;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    cfg_code_in <= 8'h00; // late changes must not be taken
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  function automatic logic [15:0] io_exp(input logic [7:0] c, input logic [15:0] r);
    logic [15:0] v;
    v = r;
    v[0] = 1'b0;
    if (c == 8'h02) begin v[2] = 1'b0; v[13] = 1'b0; end
    if (c == 8'h04 || c == 8'h07) v[15:1] = ~r[15:1];
    if (c < 8'h01 || c > 8'h07) v = '0;
    return v;
  endfunction

  initial begin
    for (int c = 1; c <= 8; c++) begin
      local_ctrl_enable_strap <= (c != 6);
      rst(8'(c));
      processor_reset_out <= 1'b1;
      nmi_in <= 1'b1;
      sys_mgmt_irq_n_in <= 1'b0;
      apb(1'b0, dig_pkg::STATUS_OFS, 0);
      chk("status", rd, {20'h0, c != 6, 2'b01, c < 8, 8'(c)});
      chk("strap", local_ctrl_enable, c != 6);
      chk("bsp_pins", boot_processor_pins, {3'b010, c >= 5 && c < 8});
      chk("ap_pins", application_processor_pins,
          (c != 6) ? {3'b000, c >= 5 && c < 8} : 4'b0010);
      apb(1'b0, dig_pkg::FEATURE_OFS, 0);
      chk("feature", rd[15:8], 8'(c));
      chk("io_inputs", io_ctrl_inputs, io_exp(8'(c), irq_lines));
      if (c < 8) chk("hard_reset", hard_reset_out, c < 5);
      if (c < 8) chk("soft_init", boot_processor_pins.soft_init, c >= 5);
      processor_reset_out <= 1'b0;
      nmi_in <= 1'b0;
      sys_mgmt_irq_n_in <= 1'b1;
    end
    rst(8'h03);
    apb(1'b0, dig_pkg::CTRL_OFS, 0);
    chk("ctrl", rd, 32'h2);
    apb(1'b1, dig_pkg::PTR_OFS, 32'hffff_ffff);
    apb(1'b0, dig_pkg::PTR_OFS, 0);
    chk("pointer", rd, 32'h0);
    apb(1'b0, 8'h18, 0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    chk("ids", {boot_processor_id, application_processor_id}, 8'h01);
    foreach (addrs[i]) begin
      @(posedge pclk) cpu_addr <= addrs[i];
      tick(1);
      chk("decode", {local_ctrl_sel, io_ctrl_sel},
          {addrs[i][31:12] == 20'hfee00, addrs[i][31:12] == 20'hfec00});
    end
    apb(1'b1, dig_pkg::MSG_OFS, 32'h1);
    tick(2);
    chk("ap_run", application_processor_run, 1'b1);
    @(posedge pclk) sys_init_in <= 1'b1;
    tick(1);
    chk("sys_init", {application_processor_run, boot_processor_pins.soft_init,
                     application_processor_pins.soft_init}, 3'b011);
    @(posedge pclk) sys_init_in <= 1'b0;
    apb(1'b1, dig_pkg::MSG_OFS, 32'h1);
    tick(2);
    chk("ap_restart", application_processor_run, 1'b1);
    apb(1'b1, dig_pkg::MSG_OFS, 32'h2);
    tick(2);
    chk("ap_init", {application_processor_run, boot_processor_pins.soft_init}, 2'b00);
    apb(1'b1, dig_pkg::MSG_OFS, 32'h4);
    tick(2);
    chk("bsp_init", {boot_processor_pins.soft_init, application_processor_pins.soft_init}, 0);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, dig_pkg::CTRL_OFS, (m < 2) ? (32'h2 | m) : 32'h0);
      @(posedge pclk);
      pic_irq_out <= 1'b1;
      tick(1);
      chk("pulse_on", {local_input0, io_ctrl_inputs[0]}, {m < 2, m < 2});
      chk("pins0", {boot_processor_pins.local_pin0, application_processor_pins.local_pin0},
          {1'b1, m == 1});
      tick(2);
      chk("pulse_off", local_input0, 1'b0);
      @(posedge pclk);
      pic_irq_out <= 1'b0;
    end
    apb(1'b1, dig_pkg::CTRL_OFS, 32'h2);
    i_cpu.do_ack(1'b1, 1'b0, 1'b1, 2, 8'h3c, 8'hc3, vec, saw, ok);
    chk("ack_pic", {ok, saw, vec}, 10'h33c);
    i_cpu.do_ack(1'b0, 1'b1, 1'b0, 1, 8'h5a, 8'ha5, vec, saw, ok);
    chk("ack_blocked", {ok, saw, vec}, 10'h2a5);
    apb(1'b0, dig_pkg::STATUS_OFS, 0);
    chk("block_flag", rd[10], 1'b1);
    apb(1'b1, dig_pkg::IN_TYPE_OFS, 32'h3);
    apb(1'b0, dig_pkg::IN_TYPE_OFS, 0);
    chk("in_type", rd, 32'h3);
    i_cpu.do_ack(1'b0, 1'b0, 1'b1, 1, 8'h77, 8'h88, vec, saw, ok);
    chk("ack_ext_type", {ok, saw, vec}, 10'h377);
    apb(1'b0, dig_pkg::STATUS_OFS, 0);
    chk("block_clear", rd[10], 1'b0);
    @(posedge pclk) ap_halts_itself <= 1'b1;
    tick(1);
    chk("self_halt", application_processor_run, 1'b1);
    complete_run();
  end
endmodule // tb_dig_level_to_edge_adapter
